// ---- efh_buf.sv ----
// parameterised first-word-fall-through buffer with registered output
`timescale 1ns/1ns
module efh_buf
   import efh_pkg::*;
#(
   parameter int WIDTH = 4,
   parameter int DEPTH = 32
)
(
   // clock, reset, enable
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // filling side
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   // draining side
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
   logic [AW:0] count_reg, count_next;
   logic in_ready_reg, in_ready_next;
   logic out_valid_reg, out_valid_next;
   logic [WIDTH-1:0] out_data_reg, out_data_next;
   logic push, load;

   // pointer, count and output stage next values
   always_comb
   begin
      push = in_valid_i && in_ready_reg;
      load = (count_reg != '0) && (!out_valid_reg || out_ready_i);
      wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
      rd_ptr_next = load ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
      count_next = count_reg + (AW+1)'(push) - (AW+1)'(load);
      in_ready_next = count_next < DEPTH_C;
      out_valid_next = out_valid_reg && !out_ready_i;
      out_data_next = out_data_reg;
      if (load)
      begin
         out_valid_next = 1'b1;
         out_data_next = mem[rd_ptr_reg];
      end
   end

   // registers; ready stalls the source once storage is full
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         in_ready_reg <= 1'b0;
         out_valid_reg <= 1'b0;
         out_data_reg <= '0;
      end
      else if (ce_i)
      begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg <= count_next;
         in_ready_reg <= in_ready_next;
         out_valid_reg <= out_valid_next;
         out_data_reg <= out_data_next;
      end
   end

   // storage array, no reset needed
   always_ff @(posedge sys_clk_i)
   begin
      if (ce_i && push)
      begin
         mem[wr_ptr_reg] <= in_data_i;
      end
   end

   assign in_ready_o = in_ready_reg;
   assign out_valid_o = out_valid_reg;
   assign out_data_o = out_data_reg;
endmodule

// ---- efh_dev_model.sv ----
// behavioural model of the elastic 16x4 fifo device seen at the host pins
`timescale 1ns/1ns
module efh_dev_model
#(
   parameter int DEPTH = 16,
   parameter int FAST_NS = 3,
   parameter int SLOW_NS = 60
)
(
   // ripple speed select
   input wire logic slow_i,
   // writer pins
   input wire logic master_clear_i,
   input wire logic shift_in_i,
   input wire logic [3:0] write_word_i,
   output logic input_ready_o,
   // reader pins
   input wire logic shift_out_i,
   input wire logic out_enable_n_i,
   output logic output_valid_flag_o,
   output logic [3:0] read_word_o,
   // observation for the bench
   output logic [4:0] level_o,
   output logic violation_o
);
   logic [3:0] mid_q[$];
   logic [3:0] in_stage = 4'h0;
   logic [3:0] out_stage = 4'hA;
   logic in_full = 1'b0;
   logic si_q = 1'b0;
   logic so_q = 1'b0;
   logic cleared = 1'b0;
   int t = 0;
   int lvl;
   initial
   begin
      input_ready_o = 1'b0;
      output_valid_flag_o = 1'b0;
      violation_o = 1'b0;
      level_o = 5'h00;
   end
   // released pins show the inverse of the held word, never a stale copy
   assign read_word_o = out_enable_n_i ? ~out_stage : out_stage;
   // one ripple step per nanosecond, at most one position per step
   always #1
   begin
      lvl = mid_q.size() + int'(in_full) + int'(output_valid_flag_o);
      if (shift_in_i && !si_q && (!input_ready_o || !cleared))
         violation_o = 1'b1;
      // a read strobe must only rise on a presented word
      if (shift_out_i && !so_q && !output_valid_flag_o)
         violation_o = 1'b1;
      if (master_clear_i)
      begin
         mid_q.delete();
         in_full = 1'b0;
         input_ready_o = 1'b1;
         output_valid_flag_o = 1'b0;
         cleared = 1'b1;
         t = 0;
      end
      else
      begin
         if (shift_in_i && input_ready_o)
         begin
            in_stage = write_word_i;
            in_full = 1'b1;
            input_ready_o = 1'b0;
         end
         if (so_q && !shift_out_i && output_valid_flag_o)
         begin
            output_valid_flag_o = 1'b0;
            t = slow_i ? SLOW_NS : FAST_NS;
         end
         if (t > 0)
            t--;
         else if (in_full && !shift_in_i)
         begin
            mid_q.push_back(in_stage);
            in_full = 1'b0;
            t = slow_i ? SLOW_NS : FAST_NS;
         end
         else if (!output_valid_flag_o && mid_q.size() > 0 && !shift_out_i)
         begin
            out_stage = mid_q.pop_front();
            output_valid_flag_o = 1'b1;
            t = slow_i ? SLOW_NS : FAST_NS;
         end
         else if (!in_full && !input_ready_o && lvl < DEPTH)
            input_ready_o = 1'b1;
      end
      si_q = shift_in_i;
      so_q = shift_out_i;
      level_o = 5'(mid_q.size() + int'(in_full) + int'(output_valid_flag_o));
   end
endmodule

// ---- efh_host.sv ----
// host controller driving an elastic 16x4 fifo device through its pins
`timescale 1ns/1ns
module efh_host
   import efh_pkg::*;
#(
   parameter int WIDTH = WORD_W,
   parameter int DEV_WORDS = DEV_DEPTH,
   parameter int FIFO_DEPTH = BUF_DEPTH
)
(
   // clock, reset, enable
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // user write stream
   input wire logic wr_valid_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   output logic wr_ready_o,
   // user read stream
   output logic rd_valid_o,
   output logic [WIDTH-1:0] rd_data_o,
   input wire logic rd_ready_i,
   // device writer pins
   output logic master_clear_o,
   output logic shift_in_o,
   output logic [WIDTH-1:0] write_word_o,
   input wire logic input_ready_i,
   // device reader pins
   output logic shift_out_o,
   output logic out_enable_n_o,
   input wire logic output_valid_flag_i,
   input wire logic [WIDTH-1:0] read_word_i
);
   localparam logic [CNT_W-1:0] MR_LAST = CNT_W'(MR_CYC - 1);
   localparam logic [CNT_W-1:0] STB_LAST = CNT_W'(STROBE_CYC - 1);
   localparam logic [CNT_W-1:0] SET_LAST = CNT_W'(SETTLE_CYC - 1);
   localparam logic [DCNT_W-1:0] DEV_MAX = DCNT_W'(DEV_WORDS);

   // pin synchronisers
   logic [WIDTH+1:0] pin_s1_reg, pin_s2_reg;
   logic dir_s, dor_s;
   logic [WIDTH-1:0] rdw_s;
   // buffer drain side
   logic buf_valid, buf_pop;
   logic [WIDTH-1:0] buf_data;
   // writer state
   efh_wr_state_t wst_reg, wst_next;
   logic [CNT_W-1:0] wcnt_reg, wcnt_next;
   logic mr_reg, mr_next, si_reg, si_next;
   logic [WIDTH-1:0] ww_reg, ww_next;
   logic wr_fire;
   // reader state
   efh_rd_state_t rst_reg, rst_next;
   logic [CNT_W-1:0] rcnt_reg, rcnt_next;
   logic so_reg, so_next, oe_n_reg, oe_n_next;
   logic rv_reg, rv_next;
   logic [WIDTH-1:0] rd_reg, rd_next;
   logic rd_fire;
   // words believed inside the device
   logic [DCNT_W-1:0] dcnt_reg, dcnt_next;

   // two flops before any logic sees a pin
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
      end
      else if (ce_i)
      begin
         pin_s1_reg <= {input_ready_i, output_valid_flag_i, read_word_i};
         pin_s2_reg <= pin_s1_reg;
      end
   end
   assign dir_s = pin_s2_reg[WIDTH+1];
   assign dor_s = pin_s2_reg[WIDTH];
   assign rdw_s = pin_s2_reg[WIDTH-1:0];

   // user words queue here until the device can take them
   efh_buf #(.WIDTH(WIDTH), .DEPTH(FIFO_DEPTH)) u_efh_buf (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .in_valid_i(wr_valid_i),
      .in_data_i(wr_data_i),
      .in_ready_o(wr_ready_o),
      .out_valid_o(buf_valid),
      .out_data_o(buf_data),
      .out_ready_i(buf_pop)
   );

   // writer: clear once, then present word, strobe, release, wait ready
   always_comb
   begin
      wst_next = wst_reg;
      wcnt_next = wcnt_reg;
      mr_next = mr_reg;
      si_next = si_reg;
      ww_next = ww_reg;
      buf_pop = 1'b0;
      wr_fire = 1'b0;
      case (wst_reg)
         W_CLEAR:
         begin
            mr_next = 1'b1;
            wcnt_next = wcnt_reg + 8'h01;
            if (wcnt_reg == MR_LAST)
            begin
               mr_next = 1'b0;
               wcnt_next = CNT_RST;
               wst_next = W_IDLE;
            end
         end
         W_IDLE:
         begin
            // burst-safe: count caps strobes at capacity
            if (buf_valid && dir_s && dcnt_reg < DEV_MAX)
            begin
               ww_next = buf_data;
               buf_pop = 1'b1;
               wst_next = W_SETUP;
            end
         end
         W_SETUP:
         begin
            si_next = 1'b1;
            wr_fire = 1'b1;
            wcnt_next = CNT_RST;
            wst_next = W_HIGH;
         end
         W_HIGH:
         begin
            wcnt_next = wcnt_reg + 8'h01;
            if (wcnt_reg == STB_LAST)
            begin
               si_next = 1'b0;
               wcnt_next = CNT_RST;
               wst_next = W_LOW;
            end
         end
         W_LOW:
         begin
            // let the ready flag ripple and resync before trusting it
            if (wcnt_reg != SET_LAST)
               wcnt_next = wcnt_reg + 8'h01;
            else if (dir_s)
            begin
               wcnt_next = CNT_RST;
               wst_next = W_IDLE;
            end
         end
         default:
         begin
            wst_next = W_CLEAR;
            wcnt_next = CNT_RST;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         wst_reg <= W_CLEAR;
         wcnt_reg <= CNT_RST;
         mr_reg <= 1'b1;
         si_reg <= 1'b0;
         ww_reg <= '0;
      end
      else if (ce_i)
      begin
         wst_reg <= wst_next;
         wcnt_reg <= wcnt_next;
         mr_reg <= mr_next;
         si_reg <= si_next;
         ww_reg <= ww_next;
      end
   end

   // reader: idle low, rise to take a word, fall to advance the next
   always_comb
   begin
      rst_next = rst_reg;
      rcnt_next = rcnt_reg;
      so_next = so_reg;
      oe_n_next = oe_n_reg;
      rv_next = rv_reg && !rd_ready_i;
      rd_next = rd_reg;
      rd_fire = 1'b0;
      case (rst_reg)
         R_WAIT:
         begin
            if (wst_reg != W_CLEAR)
            begin
               oe_n_next = 1'b0;
               rst_next = R_IDLE;
            end
         end
         R_IDLE:
         begin
            if (dor_s && !rv_reg)
            begin
               rd_next = rdw_s;
               rv_next = 1'b1;
               so_next = 1'b1;
               rd_fire = 1'b1;
               rcnt_next = CNT_RST;
               rst_next = R_HIGH;
            end
         end
         R_HIGH:
         begin
            rcnt_next = rcnt_reg + 8'h01;
            if (rcnt_reg == STB_LAST)
            begin
               so_next = 1'b0;
               rcnt_next = CNT_RST;
               rst_next = R_LOW;
            end
         end
         R_LOW:
         begin
            // stale valid flag must clear the synchroniser first
            rcnt_next = rcnt_reg + 8'h01;
            if (rcnt_reg == SET_LAST)
            begin
               rcnt_next = CNT_RST;
               rst_next = R_IDLE;
            end
         end
         default:
         begin
            rst_next = R_WAIT;
            rcnt_next = CNT_RST;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         rst_reg <= R_WAIT;
         rcnt_reg <= CNT_RST;
         so_reg <= 1'b0;
         oe_n_reg <= 1'b1;
         rv_reg <= 1'b0;
         rd_reg <= '0;
      end
      else if (ce_i)
      begin
         rst_reg <= rst_next;
         rcnt_reg <= rcnt_next;
         so_reg <= so_next;
         oe_n_reg <= oe_n_next;
         rv_reg <= rv_next;
         rd_reg <= rd_next;
      end
   end

   // occupancy of the device chain, cleared with the master clear
   always_comb
   begin
      dcnt_next = dcnt_reg + DCNT_W'(wr_fire) - DCNT_W'(rd_fire);
      if (wst_reg == W_CLEAR)
         dcnt_next = DCNT_RST;
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         dcnt_reg <= DCNT_RST;
      else if (ce_i)
         dcnt_reg <= dcnt_next;
   end

   // outputs straight from registers
   assign master_clear_o = mr_reg;
   assign shift_in_o = si_reg;
   assign write_word_o = ww_reg;
   assign shift_out_o = so_reg;
   assign out_enable_n_o = oe_n_reg;
   assign rd_valid_o = rv_reg;
   assign rd_data_o = rd_reg;

   // checks on the pin protocol
   a_clear_quiet: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i) master_clear_o |-> !shift_in_o && !shift_out_o)
      else $error("strobe active during master clear");
   a_clear_length: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i) $fell(master_clear_o) |->
         $past(master_clear_o, 8) && wst_reg == W_IDLE)
      else $error("master clear pulse too short");
   a_si_ready: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i) $rose(shift_in_o) |-> $past(dir_s, 2))
      else $error("shift-in raised without input ready");
   a_si_width: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i) $rose(shift_in_o) |->
         shift_in_o[*2] ##1 !shift_in_o[*4])
      else $error("shift-in pulse shape wrong");
   a_dev_capacity: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i) $rose(shift_in_o) |-> dcnt_reg <= DEV_MAX)
      else $error("device capacity exceeded");
   a_so_valid: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i) $rose(shift_out_o) |-> $past(dor_s))
      else $error("shift-out raised without output valid");
   a_so_lower: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i) $rose(shift_out_o) |->
         shift_out_o[*2] ##1 !shift_out_o[*4])
      else $error("shift-out not lowered before next read");
   a_read_word: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i) $rose(shift_out_o) |->
         rd_valid_o && rd_data_o == $past(rdw_s))
      else $error("read word not captured with shift-out");
endmodule

// ---- efh_host_test.sv ----
// self-checking bench for the elastic fifo host controller
`timescale 1ns/1ns
module efh_host_test
   import efh_pkg::*;
;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic wr_valid_i = 1'b0;
   logic [3:0] wr_data_i = 4'h0;
   logic rd_ready_i = 1'b0;
   logic slow = 1'b0;
   logic wr_ready, rd_valid, mclr, sin, sout, oe_n, dir, output_valid_flag, viol;
   logic [3:0] rd_data, wword, rword, kept;
   logic [4:0] level;
   logic [3:0] exp_q[$];
   int miscompares = 0;
   int n_checks = 0;
   always #4 sys_clk_i = ~sys_clk_i;
   efh_host u_efh_host (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .ce_i(ce_i), .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i),
      .wr_ready_o(wr_ready), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
      .rd_ready_i(rd_ready_i), .master_clear_o(mclr), .shift_in_o(sin),
      .write_word_o(wword), .input_ready_i(dir), .shift_out_o(sout),
      .out_enable_n_o(oe_n), .output_valid_flag_i(output_valid_flag),
      .read_word_i(rword));
   efh_dev_model u_efh_dev_model (.slow_i(slow), .master_clear_i(mclr),
      .shift_in_i(sin), .write_word_i(wword), .input_ready_o(dir),
      .shift_out_i(sout), .out_enable_n_i(oe_n), .output_valid_flag_o(output_valid_flag),
      .read_word_o(rword), .level_o(level), .violation_o(viol));
   task automatic wrap_up();
      if (miscompares == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] want);
      n_checks++;
      if (got !== want)
      begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, want);
      end
   endtask
   // every word taken on the user side must be the oldest one written
   always @(posedge sys_clk_i)
      if (rd_valid === 1'b1 && rd_ready_i === 1'b1)
         check(8'(rd_data), exp_q.size() ? 8'(exp_q.pop_front()) : 8'hFF);
   // offer words until cnt are taken or the buffer refuses for long
   task automatic send(input int cnt, input int base, output int took);
      int idle;
      took = 0;
      idle = 0;
      @(posedge sys_clk_i);
      wr_valid_i <= 1'b1;
      wr_data_i <= 4'(base);
      while (took < cnt && idle < 400)
      begin
         @(posedge sys_clk_i);
         idle++;
         if (wr_ready === 1'b1)
         begin
            exp_q.push_back(wr_data_i);
            took++;
            idle = 0;
            wr_data_i <= 4'(base + 7 * took);
         end
      end
      wr_valid_i <= 1'b0;
   endtask
   task automatic drain(input int lim);
      int n;
      n = 0;
      rd_ready_i <= 1'b1;
      while ((exp_q.size() != 0 || level != 5'h00) && n < lim)
      begin
         @(posedge sys_clk_i);
         n++;
      end
      check(8'(exp_q.size()), 8'h00);
      check(8'(level), 8'h00);
      check(8'(viol), 8'h00);
   endtask
   // clear pulse and pin levels around a reset release
   task automatic clear_pulse();
      int n;
      n = 0;
      repeat (10) @(negedge sys_clk_i);
      check(8'({mclr, oe_n, sin, sout}), 8'h0C);
      @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      @(negedge sys_clk_i);
      while (mclr === 1'b1 && n < 100)
      begin
         @(negedge sys_clk_i);
         n++;
      end
      check(8'(n >= MR_CYC - 1 && n <= MR_CYC), 8'h01);
      repeat (3) @(negedge sys_clk_i);
      check(8'({oe_n, output_valid_flag, dir, rd_valid}), 8'h02);
      check(8'(level), 8'h00);
   endtask
   task automatic t_stream();
      int took;
      rd_ready_i <= 1'b1;
      send(20, 3, took);
      check(8'(took), 8'd20);
      drain(4000);
   endtask
   task automatic t_fill();
      int took;
      rd_ready_i <= 1'b0;
      send(80, 1, took);
      check(8'(took >= 48), 8'h01);
      check(8'(level), 8'd16);
      check(8'({wr_ready, dir, rd_valid}), 8'h01);
      check(8'(rd_data), 8'(exp_q[0]));
      slow <= 1'b1;
      drain(20000);
      slow <= 1'b0;
   endtask
   task automatic t_clear_mid();
      int took;
      rd_ready_i <= 1'b0;
      send(5, 9, took);
      check(8'(took), 8'd5);
      repeat (200) @(posedge sys_clk_i);
      kept = u_efh_dev_model.out_stage;
      sys_rst_i <= 1'b1;
      exp_q.delete();
      repeat (2) @(posedge sys_clk_i);
      clear_pulse();
      check(8'(u_efh_dev_model.out_stage), 8'(kept));
      rd_ready_i <= 1'b1;
      send(4, 2, took);
      check(8'(took), 8'd4);
      drain(4000);
   endtask
   task automatic t_enable_hold();
      int took;
      logic [4:0] lvl;
      rd_ready_i <= 1'b0;
      send(3, 5, took);
      check(8'(took), 8'd3);
      ce_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      lvl = level;
      repeat (60) @(posedge sys_clk_i);
      check(8'(level), 8'(lvl));
      ce_i <= 1'b1;
      drain(4000);
   endtask
   // cut a hang short well beyond the expected run time
   initial
   begin
      #(50000 * 8); // 50k clock periods, above all drain limits together
      miscompares++;
      wrap_up();
   end
   initial
   begin
      clear_pulse();
      t_stream();
      t_fill();
      t_clear_mid();
      t_enable_hold();
      wrap_up();
   end
endmodule

// ---- efh_pkg.sv ----
// constants and state types shared by the elastic fifo host controller
package efh_pkg;
   // clock and timing
   localparam int CLK_MHZ = 125;
   localparam int MR_PULSE_NS = 100;
   localparam int STROBE_NS = 15;
   localparam int MR_CYC = (MR_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int SETTLE_CYC = 4;
   // widths, depths and reset values
   localparam int WORD_W = 4;
   localparam int DEV_DEPTH = 16;
   localparam int BUF_DEPTH = 32;
   localparam int CNT_W = 8;
   localparam int DCNT_W = 8;
   localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
   localparam logic [DCNT_W-1:0] DCNT_RST = 8'h00;
   // writer and reader state machines
   typedef enum logic [2:0] {W_CLEAR, W_IDLE, W_SETUP, W_HIGH, W_LOW}
      efh_wr_state_t;
   typedef enum logic [1:0] {R_WAIT, R_IDLE, R_HIGH, R_LOW} efh_rd_state_t;
endpackage
